// ---- design/pin_sync.sv ----
// two flip-flop synchroniser for a bus of pin inputs
// assumes the pins are asynchronous to clock
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [WIDTH-1:0] pin_in, // raw pins
   output logic [WIDTH-1:0] pin_out // synchronised pins
);
   logic [WIDTH-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         pin_out <= '0;
      end else begin
         meta_ff <= pin_in;
         pin_out <= meta_ff;
      end
   end
endmodule // pin_sync

// ---- design/spi_port.sv ----
// serial peripheral port, master or slave, one byte full duplex per exchange
// assumes a plain register port on clock; serial pins are asynchronous
// Operation
// - idle clock low or high by polarity
// - first clock edge leaves the idle level
// - phase bit picks leading or trailing sample
// - data changes half period before sampling
// - rate bits pick four master bit rates
// - slave shifts on the external master clock
// - master select and system enable bits
// - interrupt when any flag and enable set
// - done flag: status read then data access
// - data write mid-exchange sets collision only
// - collision cleared by status then data access
// - mode fault disables outputs, master, enable
// - mode fault cleared by status then control write
// - master data write starts exchange and clock
// - slave preloaded byte shifts out meanwhile
// - eight bits out and in, readable after
// - fault when master, select input, select low
// - slave ignores clock, floats output unselected
`include "spi_port_map.svh"
module spi_port (
   input wire logic clock, // system clock, 125 MHz
   input wire logic rst, // async reset, active high
   input wire logic [1:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   output logic irq, // interrupt request, active high
   input wire logic sck_in, // serial clock pin level
   output logic sck_out, // serial clock drive
   output logic sck_oe, // serial clock enable
   input wire logic mosi_in, // master-out pin level
   output logic mosi_out, // master-out drive
   output logic mosi_oe, // master-out enable
   input wire logic miso_in, // master-in pin level
   output logic miso_out, // master-in drive
   output logic miso_oe, // master-in enable
   input wire logic ss_n_in, // slave select pin level, low active
   output logic ss_n_out, // slave select drive
   output logic ss_n_oe // slave select enable
);
   localparam int DIV0 = `CLK_MHZ * 1000 / (2 * `RATE_KHZ_0);
   localparam int DIV1 = `CLK_MHZ * 1000 / (2 * `RATE_KHZ_1);
   localparam int DIV2 = `CLK_MHZ * 1000 / (2 * `RATE_KHZ_2);
   localparam int DIV3 = `CLK_MHZ * 1000 / (2 * `RATE_KHZ_3);
   localparam logic [7:0] CTL_INIT = `CONTROL_RESET;

   logic [7:0] control_ff;
   logic [3:0] direction_ff;
   logic done_ff, coll_ff, fault_ff;
   logic status_seen_ff;
   logic [7:0] shift_ff, rx_ff;
   logic [2:0] bit_ff;
   logic [8:0] div_ff;
   logic sck_ff, mo_ff;
   spi_port_pkg::shift_state_e state_ff;
   logic [3:0] pins_s;
   logic sck_s, mosi_s, miso_s, ss_n_s, sck_prev_ff;

   pin_sync #(.WIDTH(4)) u_sync (
      .clock(clock),
      .rst(rst),
      .pin_in({sck_in, mosi_in, miso_in, ss_n_in}),
      .pin_out(pins_s)
   );
   assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;

   // half bit period in system clocks for a rate code
   function automatic logic [8:0] half_period(input logic [1:0] code);
      unique case (code)
         2'b00: half_period = 9'(DIV0);
         2'b01: half_period = 9'(DIV1);
         2'b10: half_period = 9'(DIV2);
         2'b11: half_period = 9'(DIV3);
      endcase
   endfunction

   wire enabled = control_ff[`CTL_ENABLE];
   wire is_master = control_ff[`CTL_MASTER];
   wire idle_lvl = control_ff[`CTL_IDLE_LEVEL];
   wire sample_edge_select = control_ff[`CTL_EDGE_SEL];
   wire busy = state_ff != spi_port_pkg::ST_IDLE;
   wire wr_ctl = wr && addr == `ADDR_CONTROL;
   wire wr_data = wr && addr == `ADDR_DATA;
   wire rd_data = rd && addr == `ADDR_DATA;
   wire rd_stat = rd && addr == `ADDR_STATUS;
   wire data_acc = wr_data || rd_data;
   // fault needs master, select pin as input, and select low
   wire fault_now = enabled && is_master && !direction_ff[`DIR_SS] && !ss_n_s;
   // slave edge detection on the synchronised pin clock
   wire slave_sel = enabled && !is_master && !ss_n_s;
   wire s_edge = slave_sel && (sck_s != sck_prev_ff);
   // leading edge leaves idle level
   wire s_lead = s_edge && (sck_s != idle_lvl);
   wire s_trail = s_edge && (sck_s == idle_lvl);
   wire m_tick = is_master && busy && div_ff == 9'h000;
   // master samples as the first half ends; the clock shape makes that leading or trailing
   wire m_sample = m_tick && state_ff == spi_port_pkg::ST_LEAD;
   wire s_sample = sample_edge_select ? s_trail : s_lead;
   wire s_shift = sample_edge_select ? s_lead : s_trail;
   wire sample_ev = m_sample || s_sample;
   wire last_bit = bit_ff == 3'h7;
   wire finish = (m_tick && state_ff == spi_port_pkg::ST_TRAIL && last_bit)
      || (!is_master && s_sample && last_bit);
   wire rx_bit = is_master ? miso_s : mosi_s;

   // control register: fault forces slave and off
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         control_ff <= `CONTROL_RESET;
      end else if (fault_now) begin
         control_ff[`CTL_MASTER] <= 1'b0;
         control_ff[`CTL_ENABLE] <= 1'b0;
      end else if (wr_ctl) begin
         control_ff <= wdata;
      end
   end

   // pin direction bits, cleared on mode fault so outputs float
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         direction_ff <= `DIRECTION_RESET;
      end else if (fault_now) begin
         direction_ff <= 4'h0;
      end else if (wr && addr == `ADDR_DIRECTION) begin
         direction_ff <= wdata[3:0];
      end
   end

   // remembers a status read that saw a flag, arming the clears
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_seen_ff <= 1'b0;
      end else if (rd_stat) begin
         status_seen_ff <= done_ff || coll_ff || fault_ff;
      end else if (data_acc || wr_ctl) begin
         status_seen_ff <= 1'b0;
      end
   end

   // done flag; set wins over the clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else if (finish) begin
         done_ff <= 1'b1;
      end else if (status_seen_ff && data_acc) begin
         done_ff <= 1'b0;
      end
   end

   // collision flag; the running byte is left untouched
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         coll_ff <= 1'b0;
      end else if (wr_data && busy) begin
         coll_ff <= 1'b1;
      end else if (status_seen_ff && data_acc) begin
         coll_ff <= 1'b0;
      end
   end

   // mode fault flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_ff <= 1'b0;
      end else if (fault_now) begin
         fault_ff <= 1'b1;
      end else if (status_seen_ff && wr_ctl) begin
         fault_ff <= 1'b0;
      end
   end

   // sequencer: master walks lead/trail halves, slave follows pin edges
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= spi_port_pkg::ST_IDLE;
         bit_ff <= 3'h0;
         div_ff <= 9'h000;
      end else if (!enabled || fault_now) begin
         state_ff <= spi_port_pkg::ST_IDLE;
         bit_ff <= 3'h0;
      end else if (is_master) begin
         unique case (state_ff)
            spi_port_pkg::ST_IDLE: begin
               if (wr_data) begin
                  state_ff <= spi_port_pkg::ST_LEAD;
                  bit_ff <= 3'h0;
                  div_ff <= half_period(control_ff[1:0]) - 9'h001;
               end
            end
            spi_port_pkg::ST_LEAD: begin
               if (m_tick) begin
                  state_ff <= spi_port_pkg::ST_TRAIL;
                  div_ff <= half_period(control_ff[1:0]) - 9'h001;
               end else begin
                  div_ff <= div_ff - 9'h001;
               end
            end
            spi_port_pkg::ST_TRAIL: begin
               if (m_tick) begin
                  state_ff <= last_bit ? spi_port_pkg::ST_IDLE : spi_port_pkg::ST_LEAD;
                  bit_ff <= bit_ff + 3'h1;
                  div_ff <= half_period(control_ff[1:0]) - 9'h001;
               end else begin
                  div_ff <= div_ff - 9'h001;
               end
            end
         endcase
      end else begin
         // slave: exchange runs while selected, clocked by master edges
         if (!slave_sel) begin
            state_ff <= spi_port_pkg::ST_IDLE;
            bit_ff <= 3'h0;
         end else if (s_sample) begin
            state_ff <= last_bit ? spi_port_pkg::ST_IDLE : spi_port_pkg::ST_TRAIL;
            bit_ff <= bit_ff + 3'h1;
         end else if (s_lead) begin
            state_ff <= spi_port_pkg::ST_LEAD;
         end
      end
   end

   // previous pin clock level for slave edge detection
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sck_prev_ff <= 1'b0;
      end else begin
         sck_prev_ff <= sck_s;
      end
   end

   // shift register: msb first, load on idle data write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_ff <= 8'h00;
      end else if (wr_data && !busy) begin
         shift_ff <= wdata;
      end else if (sample_ev) begin
         shift_ff <= {shift_ff[6:0], rx_bit};
      end
   end

   // received byte held for reading after completion
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_ff <= 8'h00;
      end else if (finish) begin
         // a master took its last bit half a period earlier, a slave takes it now
         rx_ff <= sample_ev ? {shift_ff[6:0], rx_bit} : shift_ff;
      end
   end

   // outgoing bit: msb presented, then next bit on the shift edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mo_ff <= 1'b0;
      end else if (wr_data && !busy) begin
         mo_ff <= wdata[7];
      end else if ((m_tick && state_ff == spi_port_pkg::ST_TRAIL) || s_shift) begin
         mo_ff <= shift_ff[7];
      end
   end

   // master clock pin: moves on the same ticks as the data, so each half is exactly one count;
   // phase 1 leaves idle at the start so its trailing edge falls on the sample tick
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sck_ff <= CTL_INIT[`CTL_IDLE_LEVEL];
      end else if (!enabled || !is_master || fault_now) begin
         sck_ff <= idle_lvl;
      end else if (!busy) begin
         sck_ff <= (wr_data && sample_edge_select) ? ~idle_lvl : idle_lvl;
      end else if (m_tick && state_ff == spi_port_pkg::ST_LEAD) begin
         sck_ff <= ~sck_ff;
      end else if (m_tick) begin
         sck_ff <= (sample_edge_select && !last_bit) ? ~idle_lvl : idle_lvl;
      end
   end

   // pin drives; off whenever disabled or direction bit clear
   assign sck_out = sck_ff;
   assign sck_oe = enabled && is_master && direction_ff[`DIR_SCK];
   assign mosi_out = mo_ff;
   assign mosi_oe = enabled && is_master && direction_ff[`DIR_MOSI];
   assign miso_out = mo_ff;
   assign miso_oe = enabled && !is_master && !ss_n_s && direction_ff[`DIR_MISO];
   assign ss_n_out = 1'b1;
   assign ss_n_oe = 1'b0;
   assign irq = control_ff[`CTL_IRQ_EN] && (done_ff || coll_ff || fault_ff);

   // read data, valid the cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            `ADDR_CONTROL: rdata <= control_ff;
            `ADDR_STATUS: rdata <= {done_ff, coll_ff, 1'b0, fault_ff, 4'h0};
            `ADDR_DATA: rdata <= rx_ff;
            `ADDR_DIRECTION: rdata <= {4'h0, direction_ff};
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule // spi_port

// ---- inc/spi_port_map.svh ----
// register map, field positions, reset values and timing for the serial port
// assumes the main design includes it once by bare name
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define ADDR_CONTROL 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_DATA 2'h2
`define ADDR_DIRECTION 2'h3
`define CTL_RATE_LO 0
`define CTL_RATE_HI 1
`define CTL_IDLE_LEVEL 2
`define CTL_EDGE_SEL 3
`define CTL_MASTER 4
`define CTL_WIRED_OR 5
`define CTL_ENABLE 6
`define CTL_IRQ_EN 7
`define STS_MODE_FAULT 4
`define STS_COLLISION 6
`define STS_DONE 7
`define DIR_MISO 0
`define DIR_MOSI 1
`define DIR_SCK 2
`define DIR_SS 3
`define CONTROL_RESET 8'h04
`define DIRECTION_RESET 4'h0
`define CLK_MHZ 125
`define RATE_KHZ_0 2000
`define RATE_KHZ_1 1000
`define RATE_KHZ_2 250
`define RATE_KHZ_3 125
`endif

// ---- inc/spi_port_pkg.sv ----
// types shared by the serial port design
// assumes nothing beyond a SystemVerilog compiler
package spi_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_TRAIL = 2'b11
   } shift_state_e;
endpackage

// ---- test/spi_peer.sv ----
// far-side slave: sends one byte on master-in while taking one in, top bit first
// assumes the bench gives select and mode; clock is the port's clock pin
module spi_peer (
   input wire logic sel_n, // select, low active
   input wire logic sck, // clock pin
   input wire logic mosi, // master-out pin
   input wire logic clock_idle_level, // clock idle level
   input wire logic sample_edge_select, // sample on trailing edge when set
   input wire logic [7:0] tx, // byte to send
   output logic miso, // master-in drive
   output logic [7:0] rx // byte taken in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh;
   initial miso = 1'b0;
   // load on phase-0 select; otherwise toggle so a stale level never passes for data
   always @(sel_n) begin
      if (!sel_n && !sample_edge_select) begin
         miso = tx[7];
         sh = tx << 1;
      end else begin
         miso = ~miso;
         sh = tx;
      end
   end
   // leading edge leaves the idle level; sample edge is leading for phase 0
   always @(sck) begin
      if (!sel_n && ((sck != clock_idle_level) ^ sample_edge_select)) rx = {rx[6:0], mosi};
      else if (!sel_n) begin
         miso = sh[7];
         sh = sh << 1;
      end
   end
endmodule // spi_peer

// ---- test/spi_port_bench.sv ----
// self-checking bench: register port, master in all modes and rates, fault, slave
// assumes spi_peer on the far side and spi_port_sva bound to the port
`include "spi_port_map.svh"
module spi_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, wr = 0, rd = 0, first;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, got, stx, mtx, peer_rx;
   logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe, peer_miso;
   logic sck_d = 0, mosi_d = 0, ss_d = 1, sel_n = 1, clock_idle_level = 0, sample_edge_select = 0;
   wire logic sck_pin = sck_oe ? sck_out : sck_d;
   wire logic mosi_pin = mosi_oe ? mosi_out : mosi_d;
   wire logic miso_pin = miso_oe ? miso_out : peer_miso;
   int errors = 0, compares = 0, seed = 27191, edges = 0, half = 0, tlast = 0, n;
   always #4 clock = ~clock;
   spi_port spi_port_i (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .sck_in(sck_pin), .sck_out, .sck_oe,
      .mosi_in(mosi_pin), .mosi_out, .mosi_oe, .miso_in(miso_pin), .miso_out, .miso_oe, .ss_n_in(ss_d), .ss_n_out,
      .ss_n_oe);
   spi_peer spi_peer_i (.sel_n, .sck(sck_pin), .mosi(mosi_pin), .clock_idle_level, .sample_edge_select, .tx(stx), .miso(peer_miso), .rx(peer_rx));
   // clock pin edges: first direction and the second-to-third interval
   always @(sck_pin) begin
      edges++;
      if (edges == 1) first = sck_pin;
      if (edges == 3) half = int'($time) - tlast;
      tlast = int'($time);
   end
   function automatic int khz(input int r);
      return r == 0 ? 2000 : r == 1 ? 1000 : r == 2 ? 250 : 125;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // a hang is cut well beyond the slowest rate
   initial begin
      #400000;
      errors++;
      end_sim;
   end
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rreg(`ADDR_CONTROL);
      chk(got, 8'h04);
      wreg(`ADDR_STATUS, 8'hFF);
      rreg(`ADDR_STATUS);
      chk(got, 8'h00);
      $display("reset values done");
      // one exchange per rate over all four modes; odd passes collide; wired-or kept 0
      for (int i = 0; i < 4; i++) begin
         clock_idle_level = i[1];
         sample_edge_select = i[0];
         sck_d = i[1];
         mtx = (i == 0) ? 8'h01 : 8'($random(seed));
         stx = 8'($random(seed));
         wreg(`ADDR_CONTROL, {4'hD, i[0], i[1], i[1:0]});
         wreg(`ADDR_DIRECTION, 8'h06);
         sel_n = 0;
         edges = 0;
         wreg(`ADDR_DATA, mtx);
         if (i[0]) wreg(`ADDR_DATA, ~mtx);
         n = 0;
         do begin
            rreg(`ADDR_STATUS);
            n++;
         end while (got[7] !== 1'b1 && n < 5000);
         chk(got, {1'b1, i[0], 6'h00});
         chk(irq, 1'b1);
         chk(16'(half / 8), 16'(62500 / khz(i)));
         chk(16'(edges), 16'd16);
         chk(first, !i[1]);
         chk(sck_out, i[1]);
         chk(peer_rx, mtx);
         rreg(`ADDR_DATA);
         chk(got, stx);
         rreg(`ADDR_STATUS);
         chk(got, 8'h00);
         sel_n = 1;
         repeat (8) @(posedge clock); // a new idle level must not land on the last data change
         $display("master pass %0d done", i);
      end
      // a low select on a master turns the port off until software clears it
      @(posedge clock);
      ss_d <= 1'b0;
      repeat (8) @(posedge clock);
      chk({irq, sck_oe, mosi_oe}, 3'b100);
      rreg(`ADDR_STATUS);
      chk(got, 8'h10);
      rreg(`ADDR_CONTROL);
      chk({got[6], got[4]}, 2'b00);
      rreg(`ADDR_DIRECTION);
      chk(got[3:0], 4'h0);
      rreg(`ADDR_DATA);
      rreg(`ADDR_STATUS);
      chk(got, 8'h10);
      ss_d <= 1'b1;
      wreg(`ADDR_CONTROL, 8'h00);
      rreg(`ADDR_STATUS);
      chk(got, 8'h00);
      edges = 0;
      wreg(`ADDR_DATA, 8'h5A);
      repeat (200) @(posedge clock);
      chk(16'(edges), 16'd0);
      $display("fault done");
      // slave: preloaded byte leaves while the bench clocks one in at 64 ns
      sck_d = 1'b0; // phase-0 slave clock rests low before select, else the first edge is lost
      wreg(`ADDR_DIRECTION, 8'h01);
      wreg(`ADDR_CONTROL, 8'h40);
      stx = 8'($random(seed));
      mtx = 8'($random(seed));
      wreg(`ADDR_DATA, stx);
      #3 ss_d = 0;
      #64;
      for (int b = 7; b >= 0; b--) begin
         mosi_d = mtx[b];
         #32 got[b] = miso_out;
         sck_d = 1;
         #32 sck_d = 0;
      end
      chk(got, stx);
      #64 ss_d = 1;
      repeat (4) @(posedge clock);
      chk({miso_oe, irq}, 2'b00);
      rreg(`ADDR_STATUS);
      chk(got, 8'h80);
      rreg(`ADDR_DATA);
      chk(got, mtx);
      $display("slave done");
      end_sim;
   end
endmodule // spi_port_bench

// ---- test/spi_port_sva.sv ----
// pin and register-port checks for the serial port
// assumes the select pin stays an input and the port runs on one clock
module spi_port_sva (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic irq, // interrupt request
   input wire logic sck_out, // clock drive
   input wire logic sck_oe, // clock enable
   input wire logic mosi_out, // master-out drive
   input wire logic mosi_oe, // master-out enable
   input wire logic miso_oe, // master-in enable
   input wire logic ss_n_in, // select pin level
   input wire logic ss_n_out, // select drive
   input wire logic ss_n_oe // select enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   // select pulled low while this port drives the clock: a second master
   sequence s_fault;
      $fell(ss_n_in) && sck_oe;
   endsequence
   a_select_input: assert property (ss_n_out && !ss_n_oe)
      else $error("select pin driven");
   a_read_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   a_data_settled: assert property ($changed(mosi_out) && mosi_oe |=> $stable(sck_out) [*8])
      else $error("clock edge too close to data change");
   a_rate_floor: assert property ($changed(sck_out) && sck_oe |=> $stable(sck_out) [*8])
      else $error("clock half period too short");
   a_fault_release: assert property (s_fault |-> ##[1:6] !sck_oe && !mosi_oe)
      else $error("outputs still driven after fault");
   a_fault_holds: assert property (s_fault ##1 !wr [*8] |-> !sck_oe && !mosi_oe)
      else $error("outputs came back without software");
   a_slave_float: assert property (ss_n_in [*4] |-> !miso_oe)
      else $error("master-in driven while unselected");
   a_flag_clear_cause: assert property ($fell(irq) |-> $past(wr) || $past(rd))
      else $error("flag dropped without register access");
endmodule // spi_port_sva
bind spi_port spi_port_sva spi_port_sva_i (.clock, .rst, .wr, .rd, .rdata, .irq, .sck_out, .sck_oe, .mosi_out,
   .mosi_oe, .miso_oe, .ss_n_in, .ss_n_out, .ss_n_oe);
